// >>> rtl/cache_use_monitor_config.sv
// cache storage usage monitor configuration bank with per-security-state monitor sets
`timescale 1ns/1ps
`include "cache_use_regs.svh"
module cache_use_monitor_config
   import cache_use_pkg::*;
#(
   parameter bit MONITORS_PRESENT = 1'b1,
   parameter bit CSU_PRESENT = 1'b1,
   parameter bit HAS_CAPTURE = 1'b1,
   parameter bit CLEAR_USEFUL = 1'b1,
   parameter bit OFLOW_POSSIBLE = 1'b1,
   parameter bit HAS_OFLOW_IRQ = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire req_t req_i,
   input wire logic [MON_W-1:0] sel_mon_s_i,
   input wire logic [MON_W-1:0] sel_mon_ns_i,
   input wire logic [RIS_W-1:0] sel_ris_s_i,
   input wire logic [RIS_W-1:0] sel_ris_ns_i,
   input wire usage_t usage_i,
   input wire logic [6:1] ext_capture_i,
   input wire logic soft_capture_s_i,
   input wire logic soft_capture_all_i,
   input wire logic soft_capture_ns_i,
   output logic [31:0] rdata_o,
   output logic rvalid_o,
   output logic [2*NUM_RIS*NUM_MON-1:0] overflow_irq_o,
   output logic [2*NUM_RIS*NUM_MON-1:0][VAL_W-1:0] captured_measurement_o,
   output logic [2*NUM_RIS*NUM_MON-1:0][VAL_W-1:0] storage_measurement_o
);
   localparam int N = 2 * NUM_RIS * NUM_MON;
   localparam int IW = $clog2(N);

   ctl_t ctl_q [N];
   flt_t flt_q [N];
   logic [VAL_W-1:0] meas_q [N];
   logic [VAL_W-1:0] capt_q [N];
   logic frozen_q [N];
   logic [N-1:0] irq_q;

   logic present;
   logic [IW-1:0] acc_idx;
   logic acc_ctl;
   logic acc_flt;

   assign present = MONITORS_PRESENT & CSU_PRESENT;

   // security state picks the bank, selector picks instance within it
   always_comb begin
      if (req_i.secure) begin
         acc_idx = IW'({1'b1, sel_ris_s_i, sel_mon_s_i});
      end else begin
         acc_idx = IW'({1'b0, sel_ris_ns_i, sel_mon_ns_i});
      end
      acc_ctl = present && req_i.valid && req_i.offset == `CU_CONTROL_OFS;
      acc_flt = present && req_i.valid && req_i.offset == `CU_FILTER_OFS;
   end

   function automatic logic [31:0] ctl_word(input ctl_t c);
      logic [31:0] w;
      w = `CU_RESET_WORD;
      w[`CU_BIT_ENABLE] = c.enable;
      w[`CU_CAPT_HI:`CU_CAPT_LO] = HAS_CAPTURE ? c.capt_src : 3'h0;
      w[`CU_BIT_CLEAR] = c.clear_after_capture;
      w[`CU_BIT_OFLOW] = c.overflow_seen;
      w[`CU_BIT_IRQEN] = c.overflow_irq_enable;
      w[`CU_BIT_FREEZE] = c.freeze_on_overflow;
      w[`CU_BIT_GROUP_EN] = c.group_filter_enable;
      w[`CU_BIT_PART_EN] = c.partition_filter_enable;
      w[7:0] = `CU_TYPE_CODE;
      return w;
   endfunction

   // read path: absent bank and unmapped offsets read zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= `CU_RESET_WORD;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= req_i.valid && !req_i.write;
         if (acc_ctl) begin
            rdata_o <= ctl_word(ctl_q[acc_idx]);
         end else if (acc_flt) begin
            rdata_o <= {8'h00, flt_q[acc_idx]};
         end else begin
            rdata_o <= `CU_RESET_WORD;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_mon
         localparam bit SEC = (g >= N / 2);
         localparam int RESOURCE_INSTANCE_SELECT = (g / NUM_MON) % NUM_RIS;
         logic match;
         logic capture;
         logic [VAL_W:0] sum;
         logic [VAL_W-1:0] diff;
         logic wrap;
         logic wr_ctl;
         logic clr_oflow;

         always_comb begin
            match = usage_i.valid && usage_i.secure == SEC
               && usage_i.resource_instance_select == RIS_W'(RESOURCE_INSTANCE_SELECT)
               && ctl_q[g].enable;
            // group filter alone treated as group and partition filtering
            if (ctl_q[g].partition_filter_enable || ctl_q[g].group_filter_enable) begin
               match = match && usage_i.partition_id == flt_q[g].partition_id;
            end
            if (ctl_q[g].group_filter_enable) begin
               match = match && usage_i.perf_group_id == flt_q[g].perf_group_id;
            end
            unique case (ctl_q[g].capt_src)
               `CU_CAPT_NONE: capture = 1'b0;
               `CU_CAPT_SOFT: capture = SEC ? soft_capture_s_i
                  : (soft_capture_ns_i | (soft_capture_s_i & soft_capture_all_i));
               default: capture = ext_capture_i[ctl_q[g].capt_src];
            endcase
            capture = capture && HAS_CAPTURE;
            sum = {1'b0, meas_q[g]} + {{(VAL_W - 7){1'b0}}, usage_i.amount};
            diff = meas_q[g] - {{(VAL_W - 8){1'b0}}, usage_i.amount};
            wrap = match && !usage_i.release_line && sum[VAL_W] && OFLOW_POSSIBLE;
            wr_ctl = acc_ctl && req_i.write && acc_idx == IW'(g);
            clr_oflow = wr_ctl && !req_i.wdata[`CU_BIT_OFLOW];
         end

         // control register; hardware overflow set wins over a software clear
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               ctl_q[g] <= '0;
            end else if (ce_i) begin
               if (wr_ctl) begin
                  ctl_q[g].enable <= req_i.wdata[`CU_BIT_ENABLE];
                  ctl_q[g].capt_src <= HAS_CAPTURE
                     ? req_i.wdata[`CU_CAPT_HI:`CU_CAPT_LO] : 3'h0;
                  ctl_q[g].clear_after_capture <= HAS_CAPTURE && CLEAR_USEFUL
                     && req_i.wdata[`CU_BIT_CLEAR];
                  ctl_q[g].overflow_irq_enable <= HAS_OFLOW_IRQ && OFLOW_POSSIBLE
                     && req_i.wdata[`CU_BIT_IRQEN];
                  ctl_q[g].freeze_on_overflow <= OFLOW_POSSIBLE
                     && req_i.wdata[`CU_BIT_FREEZE];
                  ctl_q[g].group_filter_enable <= req_i.wdata[`CU_BIT_GROUP_EN];
                  ctl_q[g].partition_filter_enable <= req_i.wdata[`CU_BIT_PART_EN];
               end
               if (wrap) begin
                  ctl_q[g].overflow_seen <= 1'b1;
               end else if (clr_oflow) begin
                  ctl_q[g].overflow_seen <= 1'b0;
               end
            end
         end

         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               flt_q[g] <= '0;
            end else if (ce_i && acc_flt && req_i.write && acc_idx == IW'(g)) begin
               flt_q[g] <= req_i.wdata[23:0];
            end
         end

         // measurement: capture copies first, then optional clear
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               meas_q[g] <= '0;
               capt_q[g] <= '0;
               frozen_q[g] <= 1'b0;
            end else if (ce_i) begin
               if (capture) begin
                  capt_q[g] <= meas_q[g];
               end
               if (capture && ctl_q[g].clear_after_capture) begin
                  meas_q[g] <= '0;
                  frozen_q[g] <= 1'b0;
               end else if (frozen_q[g]) begin
                  meas_q[g] <= meas_q[g];
               end else if (match && usage_i.release_line) begin
                  meas_q[g] <= diff;
               end else if (match) begin
                  // post-increment value kept: zero after an overflowing step of one
                  meas_q[g] <= sum[VAL_W-1:0];
                  frozen_q[g] <= wrap && ctl_q[g].freeze_on_overflow;
               end
            end
         end

         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               irq_q[g] <= 1'b0;
            end else if (ce_i) begin
               irq_q[g] <= wrap && ctl_q[g].overflow_irq_enable;
            end
         end

         assign captured_measurement_o[g] = capt_q[g];
         assign storage_measurement_o[g] = meas_q[g];
      end
   endgenerate

   assign overflow_irq_o = irq_q;
endmodule

// >>> rtl/cache_use_regs.svh
// offsets, field positions, reset values and the behaviour summary for the cache use monitor bank
// Notes on behaviour
// - clear-after-capture set zeroes the measurement right after it is captured.
// - clear-after-capture reads zero and ignores writes when capture is unsupported.
// - overflow sets a sticky overflow flag, kept until software writes zero.
// - without overflow possible, overflow flag and freeze bit read zero, ignore writes.
// - overflow with interrupt enable set raises the overflow interrupt.
// - without interrupt support the interrupt enable reads zero, ignores writes.
// - freeze bit clear lets the value wrap; set holds it after overflow.
// - frozen value after an overflowing increment of one is zero.
// - the four-bit subtype field reads zero and ignores writes.
// - group filter enable restricts measurement to the configured performance group.
// - partition filter enable restricts measurement to the configured partition.
// - group filter alone behaves as if partition filtering were also on.
// - control bits 7:0 always read the type code 0x43; writes ignored.
// - secure and non-secure register copies, each reached only from its own frame.
// - accesses reach the monitor and resource instance chosen by the selector.
// - group filter value lives in filter bits 23:16, ignored when disabled.
// - partition filter value in bits 15:0; no filters measures all storage.
// - both filters on match partition and group together.
// - registers exist only when monitors and cache use monitors are present.
// - a disabled monitor collects nothing; enabled collects per its configuration.
// - capture source 0 never captures, 7 is the software trigger, others external.
`ifndef CACHE_USE_REGS_SVH
`define CACHE_USE_REGS_SVH
`define CU_FILTER_OFS 12'h810
`define CU_CONTROL_OFS 12'h818
`define CU_TYPE_CODE 8'h43
`define CU_BIT_ENABLE 31
`define CU_CAPT_HI 30
`define CU_CAPT_LO 28
`define CU_BIT_CLEAR 27
`define CU_BIT_OFLOW 26
`define CU_BIT_IRQEN 25
`define CU_BIT_FREEZE 24
`define CU_BIT_GROUP_EN 17
`define CU_BIT_PART_EN 16
`define CU_CAPT_NONE 3'h0
`define CU_CAPT_SOFT 3'h7
`define CU_RESET_WORD 32'h0000_0000
`endif

// >>> rtl/cache_use_pkg.sv
// types for the cache use monitor configuration bank
package cache_use_pkg;
   localparam int MON_W = 2;
   localparam int RIS_W = 1;
   localparam int NUM_MON = 4;
   localparam int NUM_RIS = 2;
   localparam int VAL_W = 32;

   typedef struct packed {
      logic enable;
      logic [2:0] capt_src;
      logic clear_after_capture;
      logic overflow_seen;
      logic overflow_irq_enable;
      logic freeze_on_overflow;
      logic group_filter_enable;
      logic partition_filter_enable;
   } ctl_t;

   typedef struct packed {
      logic [7:0] perf_group_id;
      logic [15:0] partition_id;
   } flt_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic secure;
      logic [11:0] offset;
      logic [31:0] wdata;
   } req_t;

   // one cache line allocation or release, tagged with its owner
   typedef struct packed {
      logic valid;
      logic release_line;
      logic secure;
      logic [RIS_W-1:0] resource_instance_select;
      logic [15:0] partition_id;
      logic [7:0] perf_group_id;
      logic [7:0] amount;
   } usage_t;
endpackage

// >>> tb/cache_use_checker_assertions.sv
// concurrent checks on the ports of the cache use monitor configuration bank
`timescale 1ns/1ps
module cache_use_checker
   import cache_use_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire req_t req_i,
   input wire logic [MON_W-1:0] sel_mon_s_i,
   input wire logic [MON_W-1:0] sel_mon_ns_i,
   input wire logic [RIS_W-1:0] sel_ris_s_i,
   input wire logic [RIS_W-1:0] sel_ris_ns_i,
   input wire usage_t usage_i,
   input wire logic [6:1] ext_capture_i,
   input wire logic soft_capture_s_i,
   input wire logic soft_capture_all_i,
   input wire logic soft_capture_ns_i,
   input wire logic [31:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [2*NUM_RIS*NUM_MON-1:0] overflow_irq_o,
   input wire logic [2*NUM_RIS*NUM_MON-1:0][VAL_W-1:0] captured_measurement_o,
   input wire logic [2*NUM_RIS*NUM_MON-1:0][VAL_W-1:0] storage_measurement_o
);
   logic rd_req;
   logic evt;
   logic act;
   assign rd_req = ce_i && req_i.valid && !req_i.write;
   assign evt = ce_i && (|ext_capture_i || soft_capture_s_i || soft_capture_ns_i);
   assign act = evt || (ce_i && usage_i.valid);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(ofs);
      rd_req && req_i.offset == ofs;
   endsequence
   a_read_gets_answer: assert property (rd_req |=> rvalid_o)
      else $error("read not answered");
   a_answer_has_cause: assert property (rvalid_o && $past(ce_i) |-> $past(rd_req))
      else $error("answer without read");
   a_write_is_silent: assert property (ce_i && req_i.valid && req_i.write |=> !rvalid_o)
      else $error("answer after write");
   a_type_code_read: assert property (s_rd(12'h818) |=> rdata_o[7:0] == 8'h43)
      else $error("type code wrong");
   a_ctl_reserved_zero: assert property (s_rd(12'h818) |=> rdata_o[23:18] == 6'h0 && rdata_o[15:8] == 8'h0)
      else $error("control reserved bits set");
   a_flt_top_zero: assert property (s_rd(12'h810) |=> rdata_o[31:24] == 8'h0)
      else $error("filter top byte set");
   a_unmapped_reads_zero: assert property (rd_req && !(req_i.offset inside {12'h810, 12'h818}) |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_store_has_cause: assert property (!$stable(storage_measurement_o) |-> $past(act))
      else $error("measurement moved without cause");
   a_capture_has_event: assert property (!$stable(captured_measurement_o) |-> $past(evt))
      else $error("capture without event");
endmodule
bind cache_use_monitor_config cache_use_checker chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .req_i(req_i), .sel_mon_s_i(sel_mon_s_i), .sel_mon_ns_i(sel_mon_ns_i), .sel_ris_s_i(sel_ris_s_i),
   .sel_ris_ns_i(sel_ris_ns_i), .usage_i(usage_i), .ext_capture_i(ext_capture_i),
   .soft_capture_s_i(soft_capture_s_i), .soft_capture_all_i(soft_capture_all_i),
   .soft_capture_ns_i(soft_capture_ns_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .overflow_irq_o(overflow_irq_o), .captured_measurement_o(captured_measurement_o),
   .storage_measurement_o(storage_measurement_o));

// >>> tb/cache_use_monitor_config_test.sv
// self-checking bench for the cache use monitor configuration bank
`timescale 1ns/1ps
module cache_use_monitor_config_test;
   import cache_use_pkg::*;
   typedef struct packed {
      logic w; logic s; logic r; logic [1:0] m; logic [11:0] ofs; logic [31:0] wd; logic [31:0] exp;
   } row_t;
   logic clk_i = 0, rst_i = 1, ce_i = 1, rvalid_o;
   req_t req_i = '0;
   usage_t usage_i = '0;
   logic [MON_W-1:0] mon_s = '0, mon_ns = '0;
   logic [RIS_W-1:0] ris_s = '0, ris_ns = '0;
   logic [6:1] ext_i = '0;
   logic [31:0] rdata_o, rd;
   logic [2*NUM_RIS*NUM_MON-1:0] irq;
   logic [2*NUM_RIS*NUM_MON-1:0][VAL_W-1:0] capt, store;
   int num_errors = 0, n_checks = 0;
   // written all ones: bit 26 cannot be set by software, reserved bits stay zero
   row_t rows[7] = '{'{1, 1, 0, 0, 12'h818, 32'hffff_ffff, 32'hfb03_0043},
      '{1, 0, 1, 3, 12'h810, 32'hffff_ffff, 32'h00ff_ffff},
      '{1, 0, 0, 2, 12'h818, 32'h0000_0000, 32'h0000_0043},
      '{1, 1, 1, 1, 12'h810, 32'h0012_3456, 32'h0012_3456},
      '{1, 1, 0, 0, 12'h814, 32'hffff_ffff, 32'h0000_0000},
      '{0, 1, 0, 0, 12'h818, 32'h0, 32'hfb03_0043},
      '{0, 0, 0, 0, 12'h818, 32'h0, 32'h0000_0043}};
   cache_use_monitor_config dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
      .sel_mon_s_i(mon_s), .sel_mon_ns_i(mon_ns), .sel_ris_s_i(ris_s), .sel_ris_ns_i(ris_ns),
      .usage_i(usage_i), .ext_capture_i(ext_i), .soft_capture_s_i(1'b0),
      .soft_capture_all_i(1'b0), .soft_capture_ns_i(1'b0), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .overflow_irq_o(irq), .captured_measurement_o(capt),
      .storage_measurement_o(store));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // both selectors follow the same index; the security bit alone picks the frame
   task acc(input logic w, s, r, input logic [1:0] m, input logic [11:0] ofs, input logic [31:0] wd);
      @(negedge clk_i);
      ris_s = r;
      mon_s = m;
      ris_ns = r;
      mon_ns = m;
      req_i = '{1'b1, w, s, ofs, wd};
      @(negedge clk_i);
      req_i.valid = 1'b0;
      rd = rdata_o;
      if (!w) chk({31'h0, rvalid_o}, 32'h1);
   endtask
   task use_line(input logic s, input logic [15:0] p, input logic [7:0] g, input logic [7:0] a);
      @(negedge clk_i);
      usage_i = '{1'b1, 1'b0, s, 1'b0, p, g, a};
      @(negedge clk_i);
      usage_i.valid = 1'b0;
   endtask
   task capture;
      @(negedge clk_i);
      ext_i[1] = 1'b1;
      @(negedge clk_i);
      ext_i[1] = 1'b0;
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 0;
      acc(0, 0, 0, 0, 12'h818, 32'h0);
      chk(rd, 32'h0000_0043);
      acc(0, 0, 0, 0, 12'h810, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i].w) acc(1, rows[i].s, rows[i].r, rows[i].m, rows[i].ofs, rows[i].wd);
         acc(0, rows[i].s, rows[i].r, rows[i].m, rows[i].ofs, 32'h0);
         chk(rd, rows[i].exp);
      end
      $display("register table test done");
      acc(1, 0, 0, 0, 12'h818, 32'h8003_0000);
      acc(1, 0, 0, 0, 12'h810, 32'h0022_0005);
      use_line(0, 16'h0005, 8'h22, 8'h10);
      chk(store[0], 32'h10);
      use_line(0, 16'h0006, 8'h22, 8'h10);
      use_line(0, 16'h0005, 8'h33, 8'h10);
      use_line(1, 16'h0005, 8'h22, 8'h10);
      chk(store[0], 32'h10);
      chk(store[2], 32'h0);
      acc(1, 0, 0, 0, 12'h818, 32'h9803_0000);
      capture();
      chk(capt[0], 32'h10);
      chk(store[0], 32'h0);
      acc(1, 0, 0, 0, 12'h818, 32'h8003_0000);
      use_line(0, 16'h0005, 8'h22, 8'h08);
      capture();
      chk(capt[0], 32'h10);
      chk(store[0], 32'h08);
      chk(irq, '0);
      $display("measurement test done");
      // a frozen clock enable must hold every measurement
      ce_i = 1'b0;
      use_line(0, 16'h0005, 8'h22, 8'h08);
      chk(store[0], 32'h08);
      ce_i = 1'b1;
      $display("clock enable test done");
      // second reset in mid-run drops measurements and configuration
      @(negedge clk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      chk(store[0], 32'h0);
      chk(capt[0], 32'h0);
      acc(0, 0, 0, 0, 12'h818, 32'h0);
      chk(rd, 32'h0000_0043);
      $display("mid-run reset test done");
      summarize();
   end
endmodule
